/* File: cflg_pkg.sv */
/*
 * cflg_pkg: constants shared by the condition flag register block.
 * assumes a single processor clock; the decoder issues one op per cycle.
 */
package cflg_pkg;
    // ------------------------------------------------------------
    // flag layout
    // ------------------------------------------------------------
    localparam int CFLG_WIDTH = 6; // width of the flag register
    localparam int CFLG_DW = 8; // alu data width
    localparam int BIT_HALF = 5; // half-carry
    localparam int BIT_MASK = 4; // interrupt mask
    localparam int BIT_NEG = 3; // negative
    localparam int BIT_ZERO = 2; // zero
    localparam int BIT_OVF = 1; // overflow
    localparam int BIT_CARRY = 0; // carry
    localparam int SIGN_BIT = 7; // sign of a byte
    localparam int NIB_W = 4; // bcd digit width
    localparam logic [5:0] FLAGS_RST = 6'h10; // mask set out of reset
    localparam logic [3:0] BCD_MAX = 4'h9; // largest decimal digit
    localparam logic [3:0] BCD_FIX = 4'h6; // decimal correction
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONE = 8'h01;
    localparam logic [7:0] BYTE_MIN = 8'h80; // -128 pattern

    // ------------------------------------------------------------
    // operation codes from the decoder
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        CFLG_OP_NONE = 5'h00,
        CFLG_OP_ADD = 5'h01,
        CFLG_OP_ADD_ACCUMULATORS = 5'h02,
        CFLG_OP_ADD_CARRY = 5'h03,
        CFLG_OP_SUB = 5'h04,
        CFLG_OP_SUB_CARRY = 5'h05,
        CFLG_OP_COMPARE = 5'h06,
        CFLG_OP_NEGATE = 5'h07,
        CFLG_OP_AND = 5'h08,
        CFLG_OP_BIT_TEST = 5'h09,
        CFLG_OP_INCLUSIVE_OR = 5'h0A,
        CFLG_OP_EXCLUSIVE_OR = 5'h0B,
        CFLG_OP_DECIMAL_ADJUST = 5'h0C,
        CFLG_OP_CLEAR_CARRY = 5'h0D,
        CFLG_OP_SET_CARRY = 5'h0E,
        CFLG_OP_CLEAR_OVERFLOW = 5'h0F,
        CFLG_OP_SET_OVERFLOW = 5'h10,
        CFLG_OP_CLEAR_MASK = 5'h11,
        CFLG_OP_SET_MASK = 5'h12,
        CFLG_OP_ACC_TO_FLAGS = 5'h13,
        CFLG_OP_FLAGS_TO_ACC = 5'h14
    } cflg_op_e;
endpackage : cflg_pkg

/* File: cflg_bcd_adj.sv */
/*
 * cflg_bcd_adj: decimal adjust correction for a packed bcd byte.
 * assumes the byte came from a binary add of two bcd bytes.
 */
module cflg_bcd_adj
    import cflg_pkg::*;
#(
    parameter int DW = CFLG_DW
) (
    // operand and incoming flags
    input wire logic [DW-1:0] value,
    input wire logic half_in,
    input wire logic carry_in,
    // corrected byte and carry
    output logic [DW-1:0] result,
    output logic carry_out
);
    // ------------------------------------------------------------
    // digit correction
    // ------------------------------------------------------------
    logic [NIB_W-1:0] lo_nib; // low digit
    logic [NIB_W-1:0] hi_nib; // high digit
    logic fix_lo; // correct low digit
    logic fix_hi; // correct high digit
    logic [DW:0] sum; // wide sum keeps carry

    assign lo_nib = value[NIB_W-1:0];
    assign hi_nib = value[DW-1:NIB_W];

    // low fix on large digit or half carry
    assign fix_lo = (lo_nib > BCD_MAX) || half_in;
    // high fix also when low digit spills into a nine
    assign fix_hi = (hi_nib > BCD_MAX) || carry_in ||
                    ((lo_nib > BCD_MAX) && (hi_nib == BCD_MAX));

    always_comb begin
        sum = {1'b0, value};
        if (fix_lo) begin
            sum = sum + {5'h00, BCD_FIX};
        end
        if (fix_hi) begin
            sum = sum + {1'b0, BCD_FIX, 4'h0};
        end
    end

    assign result = sum[DW-1:0];
    // carry never cleared if it was already set
    assign carry_out = sum[DW] || fix_hi || carry_in;
endmodule : cflg_bcd_adj

/* File: cflg_flags.sv */
/*
 * cflg_flags: six bit condition flag register and its update logic.
 * assumes the decoder presents one op with operands each cycle and
 * takes the registered alu result after the edge; flags land on the edge.
 */
// Operation
// - six bit status register inside processor
// - bits five..zero: half, mask, neg, zero, ovf, carry
// - half carry from bit three on adds only
// - mask set by interrupts, set-mask or a flag load from acc a only
// - single flag set and clear ops
// - load flags from acc a, copy out unchanged
// - flags update automatically on affecting ops
// - alu does plain binary eight bit addition
// - negate inverts then adds one
// - bit seven is the sign bit
// - negate and or update negative flag
// - carry supports unsigned byte interpretation
// - decimal adjust supports packed bcd bytes
// - decimal adjust nibble correction conditions
// - bit test sets flags like and, no write
module cflg_flags
    import cflg_pkg::*;
#(
    parameter int DW = CFLG_DW,
    parameter logic [CFLG_WIDTH-1:0] RST_VAL = FLAGS_RST
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // operation from the decoder
    input wire logic op_valid,
    input wire cflg_op_e op_code,
    input wire logic [DW-1:0] accumulator_a,
    input wire logic [DW-1:0] operand_b,
    // interrupt entry sets the mask
    input wire logic irq_taken,
    // results
    output logic [DW-1:0] alu_result_q,
    output logic acc_write_q,
    output logic [CFLG_WIDTH-1:0] condition_flags_q
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [CFLG_WIDTH-1:0] condition_flags_d; // next flags
    logic [DW-1:0] alu_result_d; // next result
    logic acc_write_d; // next write strobe
    logic [DW:0] sum_w; // adder with carry out
    logic [NIB_W:0] half_w; // low digit adder
    logic [DW-1:0] add_a; // adder input a
    logic [DW-1:0] add_b; // adder input b
    logic add_cin; // adder carry in
    logic [DW-1:0] bcd_res; // decimal adjusted byte
    logic bcd_carry; // decimal carry

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // zero test on a byte
    function automatic logic is_zero(input logic [DW-1:0] v);
        return v == BYTE_ZERO;
    endfunction : is_zero

    // signed overflow of a + b; sign is bit seven
    function automatic logic ovf_add(input logic [DW-1:0] a,
                                     input logic [DW-1:0] b,
                                     input logic [DW-1:0] r);
        return (a[SIGN_BIT] == b[SIGN_BIT]) &&
               (r[SIGN_BIT] != a[SIGN_BIT]);
    endfunction : ovf_add

    // ------------------------------------------------------------
    // shared adder: subtract is add of inverted operand
    // ------------------------------------------------------------
    always_comb begin
        add_a = accumulator_a;
        add_b = operand_b;
        add_cin = 1'b0;
        unique case (op_code)
            CFLG_OP_ADD_CARRY: begin
                add_cin = condition_flags_q[BIT_CARRY];
            end
            CFLG_OP_SUB, CFLG_OP_COMPARE: begin
                add_b = ~operand_b;
                add_cin = 1'b1;
            end
            CFLG_OP_SUB_CARRY: begin
                add_b = ~operand_b;
                add_cin = ~condition_flags_q[BIT_CARRY];
            end
            CFLG_OP_NEGATE: begin
                // invert then add one
                add_a = ~operand_b;
                add_b = BYTE_ZERO;
                add_cin = 1'b1;
            end
            default: begin
                add_cin = 1'b0;
            end
        endcase
    end

    // plain binary addition of two bytes
    assign sum_w = {1'b0, add_a} + {1'b0, add_b} +
                   {{DW{1'b0}}, add_cin};
    assign half_w = {1'b0, add_a[NIB_W-1:0]} + {1'b0, add_b[NIB_W-1:0]} +
                    {{NIB_W{1'b0}}, add_cin};

    // decimal adjust on the accumulator
    cflg_bcd_adj #(.DW(DW)) u_bcd (
        .value(accumulator_a),
        .half_in(condition_flags_q[BIT_HALF]),
        .carry_in(condition_flags_q[BIT_CARRY]),
        .result(bcd_res),
        .carry_out(bcd_carry)
    );

    // ------------------------------------------------------------
    // flag next state
    // ------------------------------------------------------------
    always_comb begin
        condition_flags_d = condition_flags_q;
        alu_result_d = BYTE_ZERO;
        acc_write_d = 1'b0;
        if (op_valid) begin
            unique case (op_code)
                CFLG_OP_ADD, CFLG_OP_ADD_ACCUMULATORS,
                CFLG_OP_ADD_CARRY: begin
                    alu_result_d = sum_w[DW-1:0];
                    acc_write_d = 1'b1;
                    condition_flags_d[BIT_HALF] = half_w[NIB_W];
                    condition_flags_d[BIT_NEG] = sum_w[SIGN_BIT];
                    condition_flags_d[BIT_ZERO] = is_zero(sum_w[DW-1:0]);
                    condition_flags_d[BIT_OVF] =
                        ovf_add(add_a, add_b, sum_w[DW-1:0]);
                    // unsigned carry out of bit seven
                    condition_flags_d[BIT_CARRY] = sum_w[DW];
                end
                CFLG_OP_SUB, CFLG_OP_SUB_CARRY, CFLG_OP_COMPARE: begin
                    alu_result_d = sum_w[DW-1:0];
                    acc_write_d = (op_code != CFLG_OP_COMPARE);
                    condition_flags_d[BIT_NEG] = sum_w[SIGN_BIT];
                    condition_flags_d[BIT_ZERO] = is_zero(sum_w[DW-1:0]);
                    condition_flags_d[BIT_OVF] =
                        ovf_add(add_a, add_b, sum_w[DW-1:0]);
                    // borrow is the inverted adder carry
                    condition_flags_d[BIT_CARRY] = ~sum_w[DW];
                end
                CFLG_OP_NEGATE: begin
                    alu_result_d = sum_w[DW-1:0];
                    acc_write_d = 1'b1;
                    condition_flags_d[BIT_NEG] = sum_w[SIGN_BIT];
                    condition_flags_d[BIT_ZERO] = is_zero(sum_w[DW-1:0]);
                    // only -128 overflows on negate
                    condition_flags_d[BIT_OVF] =
                        (sum_w[DW-1:0] == BYTE_MIN);
                    condition_flags_d[BIT_CARRY] =
                        ~is_zero(sum_w[DW-1:0]);
                end
                CFLG_OP_AND, CFLG_OP_BIT_TEST, CFLG_OP_INCLUSIVE_OR,
                CFLG_OP_EXCLUSIVE_OR: begin
                    if (op_code == CFLG_OP_INCLUSIVE_OR) begin
                        alu_result_d = accumulator_a | operand_b;
                    end else if (op_code == CFLG_OP_EXCLUSIVE_OR) begin
                        alu_result_d = accumulator_a ^ operand_b;
                    end else begin
                        alu_result_d = accumulator_a & operand_b;
                    end
                    // bit test keeps the accumulator
                    acc_write_d = (op_code != CFLG_OP_BIT_TEST);
                    condition_flags_d[BIT_NEG] =
                        alu_result_d[SIGN_BIT];
                    condition_flags_d[BIT_ZERO] = is_zero(alu_result_d);
                    condition_flags_d[BIT_OVF] = 1'b0;
                end
                CFLG_OP_DECIMAL_ADJUST: begin
                    alu_result_d = bcd_res;
                    acc_write_d = 1'b1;
                    condition_flags_d[BIT_NEG] = bcd_res[SIGN_BIT];
                    condition_flags_d[BIT_ZERO] = is_zero(bcd_res);
                    condition_flags_d[BIT_CARRY] = bcd_carry;
                end
                CFLG_OP_CLEAR_CARRY: begin
                    condition_flags_d[BIT_CARRY] = 1'b0;
                end
                CFLG_OP_SET_CARRY: begin
                    condition_flags_d[BIT_CARRY] = 1'b1;
                end
                CFLG_OP_CLEAR_OVERFLOW: begin
                    condition_flags_d[BIT_OVF] = 1'b0;
                end
                CFLG_OP_SET_OVERFLOW: begin
                    condition_flags_d[BIT_OVF] = 1'b1;
                end
                CFLG_OP_CLEAR_MASK: begin
                    condition_flags_d[BIT_MASK] = 1'b0;
                end
                CFLG_OP_SET_MASK: begin
                    condition_flags_d[BIT_MASK] = 1'b1;
                end
                CFLG_OP_ACC_TO_FLAGS: begin
                    condition_flags_d =
                        accumulator_a[CFLG_WIDTH-1:0];
                end
                CFLG_OP_FLAGS_TO_ACC: begin
                    // upper two bits read as ones
                    alu_result_d = {2'b11, condition_flags_q};
                    acc_write_d = 1'b1;
                end
                default: begin
                    acc_write_d = 1'b0;
                end
            endcase
        end
        // interrupt entry wins over a clear-mask in the same cycle
        if (irq_taken) begin
            condition_flags_d[BIT_MASK] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // registers: flags land at the end of the op
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            condition_flags_q <= RST_VAL;
            alu_result_q <= BYTE_ZERO;
            acc_write_q <= 1'b0;
        end else begin
            condition_flags_q <= condition_flags_d;
            alu_result_q <= alu_result_d;
            acc_write_q <= acc_write_d;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_carry_set;
        @(posedge clk_sys) disable iff (!rst_n)
        op_valid && op_code == CFLG_OP_SET_CARRY |=>
            condition_flags_q[BIT_CARRY];
    endproperty
    a_carry_set: assert property (p_carry_set)
        else $error("set carry did not set carry");

    property p_mask_clear;
        @(posedge clk_sys) disable iff (!rst_n)
        op_valid && op_code == CFLG_OP_CLEAR_MASK && !irq_taken |=>
            !condition_flags_q[BIT_MASK];
    endproperty
    a_mask_clear: assert property (p_mask_clear)
        else $error("clear mask failed");

    property p_mask_sticky;
        @(posedge clk_sys) disable iff (!rst_n)
        $fell(condition_flags_q[BIT_MASK]) |->
            $past(op_valid) && $past(op_code) inside
            {CFLG_OP_CLEAR_MASK, CFLG_OP_ACC_TO_FLAGS};
    endproperty
    a_mask_sticky: assert property (p_mask_sticky)
        else $error("mask cleared without clear-mask");

    property p_irq_mask;
        @(posedge clk_sys) disable iff (!rst_n)
        irq_taken |=> condition_flags_q[BIT_MASK];
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("interrupt did not set mask");

    property p_load;
        @(posedge clk_sys) disable iff (!rst_n)
        op_valid && op_code == CFLG_OP_ACC_TO_FLAGS && !irq_taken |=>
            condition_flags_q == $past(accumulator_a[CFLG_WIDTH-1:0]);
    endproperty
    a_load: assert property (p_load)
        else $error("flags not loaded from accumulator");

    property p_copy_out;
        @(posedge clk_sys) disable iff (!rst_n)
        op_valid && op_code == CFLG_OP_FLAGS_TO_ACC && !irq_taken |=>
            $stable(condition_flags_q) &&
            alu_result_q[CFLG_WIDTH-1:0] == condition_flags_q;
    endproperty
    a_copy_out: assert property (p_copy_out)
        else $error("flag copy-out altered flags");

    property p_half;
        @(posedge clk_sys) disable iff (!rst_n)
        op_valid && op_code == CFLG_OP_ADD |=>
            condition_flags_q[BIT_HALF] ==
            ($past(accumulator_a[3:0]) + $past(operand_b[3:0]) > 5'h0F);
    endproperty
    a_half: assert property (p_half)
        else $error("half carry wrong on add");

    property p_half_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        !(op_valid && op_code inside {CFLG_OP_ADD,
            CFLG_OP_ADD_ACCUMULATORS, CFLG_OP_ADD_CARRY,
            CFLG_OP_ACC_TO_FLAGS}) |=> $stable(condition_flags_q[BIT_HALF]);
    endproperty
    a_half_hold: assert property (p_half_hold)
        else $error("half carry changed by other op");

    property p_negate;
        @(posedge clk_sys) disable iff (!rst_n)
        op_valid && op_code == CFLG_OP_NEGATE |=>
            alu_result_q == 8'(-$past(operand_b)) &&
            condition_flags_q[BIT_NEG] == alu_result_q[SIGN_BIT];
    endproperty
    a_negate: assert property (p_negate)
        else $error("negate result or sign wrong");

    property p_bit_test;
        @(posedge clk_sys) disable iff (!rst_n)
        op_valid && op_code == CFLG_OP_BIT_TEST |=>
            !acc_write_q && condition_flags_q[BIT_ZERO] ==
            (($past(accumulator_a) & $past(operand_b)) == 8'h00);
    endproperty
    a_bit_test: assert property (p_bit_test)
        else $error("bit test wrong");

    c_add: cover property (@(posedge clk_sys) disable iff (!rst_n)
        op_valid && op_code == CFLG_OP_ADD ##1 condition_flags_q[BIT_HALF]);
    c_daa: cover property (@(posedge clk_sys) disable iff (!rst_n)
        op_valid && op_code == CFLG_OP_DECIMAL_ADJUST);
    c_irq_clr: cover property (@(posedge clk_sys) disable iff (!rst_n)
        irq_taken && op_valid && op_code == CFLG_OP_CLEAR_MASK);
endmodule : cflg_flags

/* File: cflg_acc_model.sv */
/*
 * cflg_acc_model: accumulator a as the decoder side keeps it.
 * assumes the flag block marks each result to be written back and
 * that the bench may load the accumulator directly, like a load op.
 */
module cflg_acc_model
    import cflg_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // direct load, standing in for a load instruction
    input wire logic ld_en,
    input wire logic [CFLG_DW-1:0] ld_val,
    // write back from the flag block
    input wire logic acc_write_q,
    input wire logic [CFLG_DW-1:0] alu_result_q,
    // accumulator seen by the flag block
    output logic [CFLG_DW-1:0] accumulator_a
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // accumulator state
    // ------------------------------------------------------------
    logic [CFLG_DW-1:0] acc_q; // current accumulator
    logic [CFLG_DW-1:0] acc_d; // next accumulator

    // write back lands one edge after the result: a dependent op
    // must leave an idle cycle, as a real decoder pipeline would
    always_comb begin
        acc_d = acc_q;
        if (ld_en) begin
            // load wins, the decoder never issues both
            acc_d = ld_val;
        end else if (acc_write_q) begin
            // only marked results are taken, bit test leaves it
            acc_d = alu_result_q;
        end
    end

    // register only
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            acc_q <= 8'h00;
        end else begin
            acc_q <= acc_d;
        end
    end

    assign accumulator_a = acc_q;
endmodule : cflg_acc_model

/* File: tb_condition_flag_register.sv */
/*
 * tb_condition_flag_register: self-checking bench for cflg_flags.
 * assumes the accumulator model writes results back one edge late;
 * inputs change at the falling edge, outputs are read just after
 * the rising edge that registers them.
 */
module tb_condition_flag_register
    import cflg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // signals and counters
    // ------------------------------------------------------------
    logic clk_sys; // 50 mhz system clock
    logic rst_n; // async reset, active low
    logic op_valid; // op present
    cflg_op_e op_code; // op from the decoder
    logic [7:0] operand_b; // second operand
    logic irq_taken; // interrupt entry pulse
    logic ld_en; // direct accumulator load
    logic [7:0] ld_val; // value to load
    logic [7:0] accumulator_a; // from the accumulator model
    logic [7:0] alu_result_q; // registered result
    logic acc_write_q; // write back marker
    logic [5:0] condition_flags_q; // the flags
    int n_mismatch; // mismatches seen
    int check_count; // comparisons made
    int cycles; // clock cycles run

    // ------------------------------------------------------------
    // clock, instances, watchdog
    // ------------------------------------------------------------
    initial clk_sys = 1'b0;
    always #10 clk_sys = ~clk_sys;

    cflg_flags i_cflg_flags (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .op_valid(op_valid),
        .op_code(op_code),
        .accumulator_a(accumulator_a),
        .operand_b(operand_b),
        .irq_taken(irq_taken),
        .alu_result_q(alu_result_q),
        .acc_write_q(acc_write_q),
        .condition_flags_q(condition_flags_q)
    );

    cflg_acc_model i_cflg_acc_model (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ld_en(ld_en),
        .ld_val(ld_val),
        .acc_write_q(acc_write_q),
        .alu_result_q(alu_result_q),
        .accumulator_a(accumulator_a)
    );

    // the tests take under a hundred cycles; this is far beyond
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: expected %h got %h",
                $time, exp, got);
        end
    endtask : chk

    // one op; er bit 8 set means the result is not compared
    task automatic op(input cflg_op_e c, input logic [7:0] b,
        input logic irq, input logic [5:0] ef, input logic [8:0] er);
        @(negedge clk_sys);
        ld_en = 1'b0;
        op_valid = 1'b1;
        op_code = c;
        operand_b = b;
        irq_taken = irq;
        @(posedge clk_sys);
        #1;
        chk({2'b00, ef}, {2'b00, condition_flags_q});
        if (er[8] == 1'b0) begin
            chk(er[7:0], alu_result_q);
        end
    endtask : op

    // idle cycle, also lets the write back land
    task automatic idle();
        @(negedge clk_sys);
        op_valid = 1'b0;
        irq_taken = 1'b0;
        ld_en = 1'b0;
        @(posedge clk_sys);
        #1;
    endtask : idle

    task automatic set_a(input logic [7:0] v);
        @(negedge clk_sys);
        op_valid = 1'b0;
        irq_taken = 1'b0;
        ld_en = 1'b1;
        ld_val = v;
        @(posedge clk_sys);
        #1;
    endtask : set_a

    task automatic end_test(input string s);
        $display("test %s done", s);
    endtask : end_test

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        cflg_op_e seq [7];
        logic [5:0] ef [7];
        seq = '{CFLG_OP_CLEAR_MASK, CFLG_OP_SET_CARRY, CFLG_OP_SET_OVERFLOW,
            CFLG_OP_SET_MASK, CFLG_OP_CLEAR_CARRY, CFLG_OP_CLEAR_OVERFLOW,
            CFLG_OP_CLEAR_MASK};
        ef = '{6'h00, 6'h01, 6'h03, 6'h13, 6'h12, 6'h10, 6'h00};
        n_mismatch = 0;
        check_count = 0;
        cycles = 0;
        rst_n = 1'b0;
        op_valid = 1'b0;
        op_code = CFLG_OP_NONE;
        operand_b = 8'h00;
        irq_taken = 1'b0;
        ld_en = 1'b0;
        ld_val = 8'h00;
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_n = 1'b1;
        chk(8'h10, {2'b00, condition_flags_q});
        chk(8'h00, {7'h00, acc_write_q});
        end_test("reset");
        // each single flag op from a known start
        for (int i = 0; i < 7; i++) begin
            op(seq[i], 8'h00, 1'b0, ef[i], 9'h100);
        end
        op(CFLG_OP_CLEAR_MASK, 8'h00, 1'b1, 6'h10, 9'h100);
        op(CFLG_OP_CLEAR_MASK, 8'h00, 1'b0, 6'h00, 9'h100);
        op(CFLG_OP_NONE, 8'h00, 1'b1, 6'h10, 9'h100);
        op(CFLG_OP_CLEAR_MASK, 8'h00, 1'b0, 6'h00, 9'h100);
        end_test("single flags");
        // add sets half carry, subtract leaves it
        set_a(8'h08);
        op(CFLG_OP_ADD, 8'h08, 1'b0, 6'h20, 9'h010);
        idle();
        chk(8'h10, accumulator_a);
        op(CFLG_OP_SUB, 8'h20, 1'b0, 6'h29, 9'h0F0);
        end_test("add and subtract");
        // negate then or, sign from bit seven
        op(CFLG_OP_NEGATE, 8'hF1, 1'b0, 6'h21, 9'h00F);
        idle();
        op(CFLG_OP_INCLUSIVE_OR, 8'h80, 1'b0, 6'h29, 9'h08F);
        op(CFLG_OP_NEGATE, 8'h00, 1'b0, 6'h24, 9'h000);
        op(CFLG_OP_NEGATE, 8'h80, 1'b0, 6'h2B, 9'h080);
        set_a(8'h7F);
        op(CFLG_OP_ADD, 8'h01, 1'b0, 6'h2A, 9'h080);
        set_a(8'hFF);
        op(CFLG_OP_ADD, 8'h01, 1'b0, 6'h25, 9'h000);
        end_test("signed and unsigned");
        // packed decimal: low fix by half carry, double fix with carry
        set_a(8'h19);
        op(CFLG_OP_ADD, 8'h28, 1'b0, 6'h20, 9'h041);
        idle();
        op(CFLG_OP_DECIMAL_ADJUST, 8'h00, 1'b0, 6'h20, 9'h047);
        set_a(8'h99);
        op(CFLG_OP_ADD, 8'h01, 1'b0, 6'h08, 9'h09A);
        idle();
        op(CFLG_OP_DECIMAL_ADJUST, 8'h00, 1'b0, 6'h05, 9'h000);
        end_test("decimal");
        // whole register to and from accumulator a
        set_a(8'h2A);
        op(CFLG_OP_ACC_TO_FLAGS, 8'h00, 1'b0, 6'h2A, 9'h100);
        op(CFLG_OP_FLAGS_TO_ACC, 8'h00, 1'b0, 6'h2A, 9'h0EA);
        chk(8'h01, {7'h00, acc_write_q});
        // bit test flags like an and, accumulator kept
        set_a(8'hF0);
        op(CFLG_OP_BIT_TEST, 8'h0F, 1'b0, 6'h24, 9'h100);
        chk(8'h00, {7'h00, acc_write_q});
        idle();
        chk(8'hF0, accumulator_a);
        end_test("transfer and bit test");
        // back to back: the add sees the carry just set
        set_a(8'h01);
        op(CFLG_OP_SET_CARRY, 8'h00, 1'b0, 6'h25, 9'h100);
        op(CFLG_OP_ADD_CARRY, 8'h01, 1'b0, 6'h00, 9'h003);
        idle();
        chk(8'h00, {2'b00, condition_flags_q});
        end_test("back to back");
        // compare and subtract with borrow, add accumulators, then the other logic ops
        op(CFLG_OP_COMPARE, 8'h04, 1'b0, 6'h09, 9'h0FF);
        chk(8'h00, {7'h00, acc_write_q});
        op(CFLG_OP_SUB_CARRY, 8'h01, 1'b0, 6'h00, 9'h001);
        idle();
        op(CFLG_OP_ADD_ACCUMULATORS, 8'h0F, 1'b0, 6'h20, 9'h010);
        idle();
        op(CFLG_OP_EXCLUSIVE_OR, 8'h90, 1'b0, 6'h28, 9'h080);
        idle();
        op(CFLG_OP_AND, 8'h7F, 1'b0, 6'h24, 9'h000);
        end_test("compare and logic");
        test_done();
    end
endmodule : tb_condition_flag_register
